/* hw/bpgc_gen_ctrl.sv */
// Bridge general control lower fields: power response, prefetch, latencies and wake control.
module bpgc_gen_ctrl #(
  parameter int NUM_SEC_CLK = 7  // Number of secondary clock outputs under this control.
) (
  // Clock and resets.
  input  wire logic                   mclk_i,                  // Bridge clock, 50 MHz.
  input  wire logic                   srst_i,                  // Power-on reset, clears all.
  input  wire logic                   pcie_fund_reset_i,       // Fundamental reset, non-sticky.
  input  wire logic                   global_reset_input_i,    // Global reset, non-sticky.

  // Configuration access.
  input  wire logic                   cfg_wr_i,                // Configuration write strobe.
  input  wire logic                   cfg_rd_i,                // Configuration read strobe.
  input  wire logic [7:0]             cfg_addr_i,              // Configuration byte address.
  input  wire logic [3:0]             cfg_byte_en_i,           // Byte enables of the access.
  input  wire logic [31:0]            cfg_wr_data_i,           // Write data.
  output logic      [31:0]            cfg_rd_data_o,           // Read data, valid with ack.
  output logic                        cfg_ack_o,               // One-cycle access answer.

  // Slot power limit messages.
  input  wire logic                   slot_limit_msg_i,        // Set slot power limit received.
  input  wire logic [7:0]             slot_limit_value_i,      // Limit value of the message.
  input  wire logic [1:0]             slot_limit_scale_i,      // Limit scale of the message.

  // Clock gating and power state.
  input  wire logic [NUM_SEC_CLK-1:0] clock_mask_i,            // Clock mask register bits.
  input  wire logic                   d3_state_i,              // Bridge is in D3.

  // Transaction verdicts.
  input  wire logic                   txn_valid_i,             // A transaction needs a verdict.
  input  wire logic                   txn_is_cfg_i,            // It is a type 0 or 1 config.
  input  wire logic                   txn_is_slot_msg_i,       // It is a set slot limit message.
  output logic                        txn_done_o,              // Verdict pulse.
  output logic                        txn_ur_o,                // Verdict: unsupported request.

  // Memory read classes.
  input  wire logic                   rd_valid_i,              // A memory read needs a class.
  input  wire logic [1:0]             rd_cmd_i,                // Read command class.
  output logic                        rd_done_o,               // Class answer pulse.
  output logic                        rd_prefetch_o,           // Read may be prefetched.

  // Power response and field copies.
  output logic                        power_exceeded_pin_o,    // Power override terminal.
  output logic [NUM_SEC_CLK-1:0]      sec_clk_enable_o,        // Secondary clock enables.
  output logic                        limit_exceeded_o,        // Slot limit below requirement.
  output logic [bpgc_pkg::MW_WIDTH-1:0] min_power_mw_o,        // Scaled requirement in mW.
  output logic [2:0]                  cap_fast_standby_latency_o,  // Capability copy.
  output logic [2:0]                  cap_deep_standby_latency_o,  // Capability copy.
  output logic                        stop_secondary_clocks_d3_o,  // Stop clocks in D3.
  output logic                        beacon_wake_o            // Use beacon with wake.
);

  // The clock mask register has seven writable bits, so more clocks cannot be served.
  if (NUM_SEC_CLK < 1 || NUM_SEC_CLK > 7) begin : g_check
    $error("NUM_SEC_CLK must lie between 1 and 7");
  end

  // All state of the block lives in this one record.
  typedef struct packed {
    // Writable fields of the register.
    logic [2:0]                  resp_sel;     // Slot power response select.
    logic                        pf_off;       // Plain read prefetch off.
    logic [2:0]                  l0s;          // Fast standby exit latency.
    logic [2:0]                  l1;           // Deep standby exit latency.
    logic                        stop_d3;      // Sticky clock stop in D3.
    logic                        beacon;       // Sticky beacon enable.
    logic [1:0]                  pscale;       // Minimum power scale.
    logic [7:0]                  pvalue;       // Minimum power value.

    // Slot limit tracking and power response.
    logic                        limit_seen;   // A slot limit message has arrived.
    logic [bpgc_pkg::MW_WIDTH-1:0] limit_mw;   // Latest slot limit in mW.
    logic [bpgc_pkg::MW_WIDTH-1:0] req_mw;     // Scaled requirement in mW.
    logic                        exceeded;     // Limit below requirement.
    logic                        pin;          // Power override terminal.
    logic [NUM_SEC_CLK-1:0]      clk_en;       // Secondary clock enables.

    // Answers of the request interfaces.
    logic [31:0]                 rd_data;      // Read data holding register.
    logic                        ack;          // Access answer.
    logic                        txn_done;     // Verdict pulse.
    logic                        txn_ur;       // Verdict value.
    logic                        rd_done;      // Read class pulse.
    logic                        rd_pf;        // Read class value.
  } bpgc_state_t;

  bpgc_state_t state_reg;   // Registered state.
  bpgc_state_t state_next;  // Next state.

  // Value after power-on reset: every field at its default, outputs idle.
  localparam bpgc_state_t STATE_RST = '{
    resp_sel:   bpgc_pkg::RESP_SEL_RST,
    pf_off:     bpgc_pkg::PF_OFF_RST,
    l0s:        bpgc_pkg::L0S_RST,
    l1:         bpgc_pkg::L1_RST,
    stop_d3:    bpgc_pkg::STOP_D3_RST,
    beacon:     bpgc_pkg::BEACON_RST,
    pscale:     bpgc_pkg::PSCALE_RST,
    pvalue:     bpgc_pkg::PVALUE_RST,
    limit_seen: 1'b0,
    limit_mw:   '0,
    req_mw:     '0,
    exceeded:   1'b0,
    pin:        1'b0,
    clk_en:     '1,
    rd_data:    '0,
    ack:        1'b0,
    txn_done:   1'b0,
    txn_ur:     1'b0,
    rd_done:    1'b0,
    rd_pf:      1'b0
  };

  // Turns a value and a scale code into milliwatts; the largest result is 255000.
  function automatic logic [bpgc_pkg::MW_WIDTH-1:0] scale_mw(input logic [7:0] value,
                                                             input logic [1:0] scale);
    logic [bpgc_pkg::MW_WIDTH-1:0] wide;
    logic [bpgc_pkg::MW_WIDTH-1:0] weight;
    // Weights are whole milliwatts, so nothing is rounded.
    wide = {10'h000, value};
    unique case (scale)
      bpgc_pkg::SCALE_X1:     weight = bpgc_pkg::MW_PER_UNIT_X1;
      bpgc_pkg::SCALE_X0P1:   weight = bpgc_pkg::MW_PER_UNIT_X0P1;
      bpgc_pkg::SCALE_X0P01:  weight = bpgc_pkg::MW_PER_UNIT_X0P01;
      bpgc_pkg::SCALE_X0P001: weight = bpgc_pkg::MW_PER_UNIT_X0P001;
    endcase
    scale_mw = wide * weight;
  endfunction : scale_mw

  logic gc_hit;       // Access addresses the general control register.
  logic soft_reset;   // Fundamental or global reset, which spares sticky bits.
  logic gate_clocks;  // Masked clocks are to be stopped.
  logic drive_pin;    // Power override terminal is to be asserted.
  logic reject;       // Non-config traffic is to be refused.

  // Decode and reset sources from the inputs; the power response from registered state.
  always_comb begin
    // The hit ignores the byte within the word.
    gc_hit      = (cfg_addr_i[7:2] == bpgc_pkg::GC_OFFSET[7:2]);
    soft_reset  = pcie_fund_reset_i | global_reset_input_i;
    // Only codes 001 to 100 act, and only while the limit is exceeded; 000 and the
    // reserved codes leave the bridge blind to the slot limit.
    gate_clocks = state_reg.exceeded &&
                  ((state_reg.resp_sel == bpgc_pkg::RESP_GATE_CLK) ||
                   (state_reg.resp_sel == bpgc_pkg::RESP_GATE_AND_PIN));
    drive_pin   = state_reg.exceeded &&
                  ((state_reg.resp_sel == bpgc_pkg::RESP_PIN) ||
                   (state_reg.resp_sel == bpgc_pkg::RESP_GATE_AND_PIN));
    reject      = state_reg.exceeded &&
                  (state_reg.resp_sel == bpgc_pkg::RESP_REJECT);
  end

  // Next-state logic for fields, limit tracking and every output.
  always_comb begin
    state_next = state_reg;

    // Configuration writes update the writable fields byte by byte; the read-only
    // virtual channel bit has no storage, so a write to it simply falls away.
    if (cfg_wr_i && gc_hit) begin
      // Byte 0: power value.
      if (cfg_byte_en_i[0]) begin
        state_next.pvalue = cfg_wr_data_i[bpgc_pkg::PVALUE_LSB +: 8];
      end
      // Byte 1: scale, wake, clock stop, deep standby.
      if (cfg_byte_en_i[1]) begin
        state_next.pscale  = cfg_wr_data_i[bpgc_pkg::PSCALE_LSB +: 2];
        state_next.beacon  = cfg_wr_data_i[bpgc_pkg::BEACON_BIT];
        state_next.stop_d3 = cfg_wr_data_i[bpgc_pkg::STOP_D3_BIT];
        state_next.l1      = cfg_wr_data_i[bpgc_pkg::L1_LSB +: 3];
      end
      // Byte 2: response, prefetch, fast standby; bit 23 unused.
      if (cfg_byte_en_i[2]) begin
        state_next.l0s      = cfg_wr_data_i[bpgc_pkg::L0S_LSB +: 3];
        state_next.pf_off   = cfg_wr_data_i[bpgc_pkg::PF_OFF_BIT];
        state_next.resp_sel = cfg_wr_data_i[bpgc_pkg::RESP_SEL_LSB +: 3];
      end
    end

    // Reads return the stored fields one cycle later; other addresses read zero.
    state_next.ack     = cfg_wr_i | cfg_rd_i;
    state_next.rd_data = '0;
    if (cfg_rd_i && gc_hit) begin
      state_next.rd_data[bpgc_pkg::RESP_SEL_LSB +: 3] = state_reg.resp_sel;
      state_next.rd_data[bpgc_pkg::PF_OFF_BIT]        = state_reg.pf_off;
      state_next.rd_data[bpgc_pkg::L0S_LSB +: 3]      = state_reg.l0s;
      state_next.rd_data[bpgc_pkg::L1_LSB +: 3]       = state_reg.l1;
      // Bit 12 has no storage and always reads zero.
      state_next.rd_data[bpgc_pkg::VC_ON_BIT]         = bpgc_pkg::VC_ON_VALUE;
      state_next.rd_data[bpgc_pkg::STOP_D3_BIT]       = state_reg.stop_d3;
      state_next.rd_data[bpgc_pkg::BEACON_BIT]        = state_reg.beacon;
      state_next.rd_data[bpgc_pkg::PSCALE_LSB +: 2]   = state_reg.pscale;
      state_next.rd_data[bpgc_pkg::PVALUE_LSB +: 8]   = state_reg.pvalue;
    end

    // The newest slot limit message replaces the previous limit.
    if (slot_limit_msg_i) begin
      state_next.limit_seen = 1'b1;
      state_next.limit_mw   = scale_mw(slot_limit_value_i, slot_limit_scale_i);
    end

    // The requirement and the comparison are each one register deep, which keeps
    // the multiplier off the path to the outputs at the cost of two cycles of lag.
    state_next.req_mw   = scale_mw(state_reg.pvalue, state_reg.pscale);
    // Until a limit has been received the slot is not judged to be short of power.
    state_next.exceeded = state_reg.limit_seen &&
                          (state_reg.limit_mw < state_reg.req_mw);

    // Power override terminal.
    state_next.pin = drive_pin;

    // Each clock runs unless its mask bit is set under clock gating, or the clock
    // stop bit is set while in D3.
    // The D3 stop covers every clock, masked or not.
    for (int i = 0; i < NUM_SEC_CLK; i++) begin
      state_next.clk_en[i] = !((gate_clocks && clock_mask_i[i]) ||
                               (d3_state_i && state_reg.stop_d3));
    end

    // Transaction verdict: refused only under code 100, and never for config
    // cycles or slot limit messages, so software can always recover the bridge.
    state_next.txn_done = txn_valid_i;
    state_next.txn_ur   = txn_valid_i && reject &&
                          !txn_is_cfg_i && !txn_is_slot_msg_i;

    // Read class: line and multiple always prefetch; plain reads only when allowed.
    state_next.rd_done = rd_valid_i;
    state_next.rd_pf   = rd_valid_i &&
                         ((rd_cmd_i != bpgc_pkg::BPGC_RD_PLAIN) ||
                          !state_reg.pf_off);

    // Fundamental and global resets restore every non-sticky field and leave the
    // clock stop and beacon bits alone, as they must survive on auxiliary power.
    // A field write in the same cycle loses to the reset.
    if (soft_reset) begin
      state_next.resp_sel = bpgc_pkg::RESP_SEL_RST;
      state_next.pf_off   = bpgc_pkg::PF_OFF_RST;
      state_next.l0s      = bpgc_pkg::L0S_RST;
      state_next.l1       = bpgc_pkg::L1_RST;
      state_next.pscale   = bpgc_pkg::PSCALE_RST;
      state_next.pvalue   = bpgc_pkg::PVALUE_RST;
      state_next.stop_d3  = state_reg.stop_d3;
      state_next.beacon   = state_reg.beacon;
    end
  end

  // State register; the power-on reset is the only one that clears sticky bits.
  always_ff @(posedge mclk_i) begin
    // Limit memory and pulses are cleared here as well.
    if (srst_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs, every one straight from the state register.
  // Bus answer.
  assign cfg_rd_data_o              = state_reg.rd_data;
  assign cfg_ack_o                  = state_reg.ack;
  // Verdict and read class pulses.
  assign txn_done_o                 = state_reg.txn_done;
  assign txn_ur_o                   = state_reg.txn_ur;
  assign rd_done_o                  = state_reg.rd_done;
  assign rd_prefetch_o              = state_reg.rd_pf;
  // Power response levels.
  assign power_exceeded_pin_o       = state_reg.pin;
  assign sec_clk_enable_o           = state_reg.clk_en;
  assign limit_exceeded_o           = state_reg.exceeded;
  assign min_power_mw_o             = state_reg.req_mw;
  // The latency codes pass unchanged; code n above zero spans step*2^(n-1) up to
  // double that, and the top code is open ended.
  assign cap_fast_standby_latency_o = state_reg.l0s;
  assign cap_deep_standby_latency_o = state_reg.l1;
  assign stop_secondary_clocks_d3_o = state_reg.stop_d3;
  assign beacon_wake_o              = state_reg.beacon;

endmodule : bpgc_gen_ctrl

/* hw/bpgc_pkg.sv */
// Package with offsets, field layout, reset values and encodings of the bridge general control.
package bpgc_pkg;

  // Byte offset of the general control register in configuration space.
  localparam logic [7:0]  GC_OFFSET          = 8'hd4;

  // Field positions inside the general control register.
  localparam int          RESP_SEL_LSB       = 20;  // Slot power response select, 22:20.
  localparam int          PF_OFF_BIT         = 19;  // Plain read prefetch off.
  localparam int          L0S_LSB            = 16;  // Fast standby exit latency, 18:16.
  localparam int          L1_LSB             = 13;  // Deep standby exit latency, 15:13.
  localparam int          VC_ON_BIT          = 12;  // Virtual channel struct on, read-only.
  localparam int          STOP_D3_BIT        = 11;  // Stop secondary clocks in D3, sticky.
  localparam int          BEACON_BIT         = 10;  // Beacon enable, sticky.
  localparam int          PSCALE_LSB         = 8;   // Minimum power scale, 9:8.
  localparam int          PVALUE_LSB         = 0;   // Minimum power value, 7:0.

  // Values after reset of each field.
  localparam logic [2:0]  RESP_SEL_RST       = 3'h0;
  localparam logic        PF_OFF_RST         = 1'b0;
  localparam logic [2:0]  L0S_RST            = 3'h0;
  localparam logic [2:0]  L1_RST             = 3'h0;
  localparam logic        VC_ON_VALUE        = 1'b0;
  localparam logic        STOP_D3_RST        = 1'b0;
  localparam logic        BEACON_RST         = 1'b0;
  localparam logic [1:0]  PSCALE_RST         = 2'h2;
  localparam logic [7:0]  PVALUE_RST         = 8'h5f;

  // Slot power response select codes; 101 to 111 are reserved and act like ignore.
  localparam logic [2:0]  RESP_IGNORE        = 3'h0;
  localparam logic [2:0]  RESP_PIN           = 3'h1;
  localparam logic [2:0]  RESP_GATE_CLK      = 3'h2;
  localparam logic [2:0]  RESP_GATE_AND_PIN  = 3'h3;
  localparam logic [2:0]  RESP_REJECT        = 3'h4;

  // Power scale codes and their weight in milliwatts per unit of value.
  localparam logic [1:0]  SCALE_X1          = 2'h0;
  localparam logic [1:0]  SCALE_X0P1        = 2'h1;
  localparam logic [1:0]  SCALE_X0P01       = 2'h2;
  localparam logic [1:0]  SCALE_X0P001      = 2'h3;
  localparam logic [17:0] MW_PER_UNIT_X1    = 18'h003e8;  // 1000 mW.
  localparam logic [17:0] MW_PER_UNIT_X0P1  = 18'h00064;  // 100 mW.
  localparam logic [17:0] MW_PER_UNIT_X0P01 = 18'h0000a;  // 10 mW.
  localparam logic [17:0] MW_PER_UNIT_X0P001 = 18'h00001; // 1 mW.
  localparam int          MW_WIDTH          = 18;

  // Lower bound of latency code 001; each higher code doubles it, 111 is open ended.
  localparam int          L0S_STEP_NS       = 64;
  localparam int          L1_STEP_NS        = 1000;

  // Memory read command classes seen on the secondary bus.
  typedef enum logic [1:0] {
    BPGC_RD_PLAIN    = 2'h0,
    BPGC_RD_LINE     = 2'h1,
    BPGC_RD_MULTIPLE = 2'h3
  } bpgc_rd_cmd_t;

endpackage : bpgc_pkg

/* tb/bpgc_gen_ctrl_checker.sv */
// Port-level assertion checker for the bridge general control block.
module bpgc_gen_ctrl_checker #(
  parameter int NUM_SEC_CLK = 7  // Width of the secondary clock enables.
) (
  input wire logic                   mclk_i,
  input wire logic                   srst_i,
  input wire logic                   pcie_fund_reset_i,
  input wire logic                   global_reset_input_i,
  input wire logic                   cfg_wr_i,
  input wire logic                   cfg_rd_i,
  input wire logic [7:0]             cfg_addr_i,
  input wire logic [31:0]            cfg_rd_data_o,
  input wire logic                   cfg_ack_o,
  input wire logic                   slot_limit_msg_i,
  input wire logic                   d3_state_i,
  input wire logic                   txn_valid_i,
  input wire logic                   txn_is_cfg_i,
  input wire logic                   txn_is_slot_msg_i,
  input wire logic                   txn_done_o,
  input wire logic                   txn_ur_o,
  input wire logic                   rd_valid_i,
  input wire logic [1:0]             rd_cmd_i,
  input wire logic                   rd_done_o,
  input wire logic                   rd_prefetch_o,
  input wire logic                   power_exceeded_pin_o,
  input wire logic [NUM_SEC_CLK-1:0] sec_clk_enable_o,
  input wire logic                   limit_exceeded_o,
  input wire logic [2:0]             cap_fast_standby_latency_o,
  input wire logic [2:0]             cap_deep_standby_latency_o,
  input wire logic                   stop_secondary_clocks_d3_o,
  input wire logic                   beacon_wake_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  logic ev;  // Any input that may move the limit comparison; kept broad on purpose.
  assign ev = slot_limit_msg_i | cfg_wr_i | pcie_fund_reset_i | global_reset_input_i;
  // Every strobe gets exactly one answer, one cycle later.
  property p_ack;
    cfg_ack_o == $past(cfg_wr_i | cfg_rd_i);
  endproperty
  a_ack: assert property (p_ack) else $error("config answer not one cycle after strobe");
  property p_rd_idle;
    !cfg_ack_o |-> cfg_rd_data_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
  property p_ro_zero;
    cfg_ack_o |-> cfg_rd_data_o[12] == 1'b0 && cfg_rd_data_o[31:23] == 9'h0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only bits not zero");
  // Copies to capability outputs agree with what a register read returns.
  property p_copy;
    cfg_ack_o && $past(cfg_rd_i) && (($past(cfg_addr_i) >> 2) == 8'h35) |->
      {cfg_rd_data_o[18:13], cfg_rd_data_o[11:10]} == {cap_fast_standby_latency_o,
      cap_deep_standby_latency_o, stop_secondary_clocks_d3_o, beacon_wake_o};
  endproperty
  a_copy: assert property (p_copy) else $error("copies differ from register");
  property p_txn_exempt;
    txn_valid_i && (txn_is_cfg_i || txn_is_slot_msg_i) |=> txn_done_o && !txn_ur_o;
  endproperty
  a_txn_exempt: assert property (p_txn_exempt) else $error("exempt transaction rejected");
  property p_rd_line;
    rd_valid_i && rd_cmd_i != 2'h0 |=> rd_done_o && rd_prefetch_o;
  endproperty
  a_rd_line: assert property (p_rd_line) else $error("line read not prefetched");
  property p_pin;
    power_exceeded_pin_o |-> $past(limit_exceeded_o);
  endproperty
  a_pin: assert property (p_pin) else $error("override pin without exceeded limit");
  property p_clk_on;
    !$past(limit_exceeded_o) && !$past(d3_state_i) |-> &sec_clk_enable_o;
  endproperty
  a_clk_on: assert property (p_clk_on) else $error("clock stopped without cause");
  property p_rise;
    $rose(limit_exceeded_o) |-> $past(ev, 2) || $past(ev, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("exceeded rose without a cause");
endmodule : bpgc_gen_ctrl_checker

bind bpgc_gen_ctrl bpgc_gen_ctrl_checker #(.NUM_SEC_CLK(NUM_SEC_CLK)) u_checker (
  .mclk_i, .srst_i, .pcie_fund_reset_i, .global_reset_input_i, .cfg_wr_i, .cfg_rd_i,
  .cfg_addr_i, .cfg_rd_data_o, .cfg_ack_o, .slot_limit_msg_i, .d3_state_i, .txn_valid_i,
  .txn_is_cfg_i, .txn_is_slot_msg_i, .txn_done_o, .txn_ur_o, .rd_valid_i, .rd_cmd_i,
  .rd_done_o, .rd_prefetch_o, .power_exceeded_pin_o, .sec_clk_enable_o, .limit_exceeded_o,
  .cap_fast_standby_latency_o, .cap_deep_standby_latency_o, .stop_secondary_clocks_d3_o,
  .beacon_wake_o);

/* tb/bpgc_gen_ctrl_tb_top.sv */
// Self-checking bench for the bridge general control block.
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module bpgc_gen_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NCLK = 7;  // Secondary clocks of the instance.
  logic        mclk_i = 1'b0, srst_i = 1'b1, pcie_fund_reset_i = 1'b0, global_reset_input_i = 1'b0;
  logic        cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, slot_limit_msg_i = 1'b0, d3_state_i = 1'b0;
  logic        txn_valid_i = 1'b0, txn_is_cfg_i = 1'b0, txn_is_slot_msg_i = 1'b0;
  logic        rd_valid_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'hd4, slot_limit_value_i = 8'h00;
  logic [3:0]  cfg_byte_en_i = 4'h0;
  logic [1:0]  slot_limit_scale_i = 2'h0, rd_cmd_i = 2'h0;
  logic [31:0] cfg_wr_data_i = 32'h0, cfg_rd_data_o, rd_data;
  logic [NCLK-1:0] clock_mask_i = 7'h55, sec_clk_enable_o;  // Alternating mask shows gating.
  logic        cfg_ack_o, txn_done_o, txn_ur_o, rd_done_o, rd_prefetch_o, power_exceeded_pin_o;
  logic        limit_exceeded_o, stop_secondary_clocks_d3_o, beacon_wake_o;
  logic [2:0]  cap_fast_standby_latency_o, cap_deep_standby_latency_o;
  logic [bpgc_pkg::MW_WIDTH-1:0] min_power_mw_o;
  int          n_mismatch = 0, samples_checked = 0;
  // Expected requirement in mW for value 5Fh at scales 00, 01, 10, 11.
  logic [17:0] exp_mw [4] = '{18'h17318, 18'h0251c, 18'h003b6, 18'h0005f};

  bpgc_gen_ctrl #(.NUM_SEC_CLK(NCLK)) dut (
    .mclk_i, .srst_i, .pcie_fund_reset_i, .global_reset_input_i, .cfg_wr_i, .cfg_rd_i,
    .cfg_addr_i, .cfg_byte_en_i, .cfg_wr_data_i, .cfg_rd_data_o, .cfg_ack_o, .slot_limit_msg_i,
    .slot_limit_value_i, .slot_limit_scale_i, .clock_mask_i, .d3_state_i, .txn_valid_i,
    .txn_is_cfg_i, .txn_is_slot_msg_i, .txn_done_o, .txn_ur_o, .rd_valid_i, .rd_cmd_i,
    .rd_done_o, .rd_prefetch_o, .power_exceeded_pin_o, .sec_clk_enable_o, .limit_exceeded_o,
    .min_power_mw_o, .cap_fast_standby_latency_o, .cap_deep_standby_latency_o,
    .stop_secondary_clocks_d3_o, .beacon_wake_o);

  // Free-running 50 MHz clock.
  initial forever #10 mclk_i = ~mclk_i;

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // One config access; the answer must come within a few cycles or the run is cut short.
  task automatic cfg_access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                            input logic [31:0] d);
    int i;
    @(negedge mclk_i);
    cfg_wr_i = wr;
    cfg_rd_i = ~wr;
    cfg_addr_i = a;
    cfg_byte_en_i = be;
    cfg_wr_data_i = d;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b0;
    for (i = 0; i < 4 && cfg_ack_o !== 1'b1; i++) @(negedge mclk_i);
    if (cfg_ack_o !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    rd_data = cfg_rd_data_o;
  endtask : cfg_access

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    cfg_access(1'b0, a, 4'h0, 32'h0);
    `CHK(rd_data, exp)
  endtask : chk_rd

  // A one-cycle pulse on a reset input.
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask : pulse

  // Slot limit message; returns once exceeded and its followers have settled.
  task automatic slot_msg(input logic [7:0] v, input logic [1:0] s);
    @(negedge mclk_i);
    slot_limit_msg_i = 1'b1;
    slot_limit_value_i = v;
    slot_limit_scale_i = s;
    @(negedge mclk_i);
    slot_limit_msg_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : slot_msg

  task automatic txn(input logic is_cfg, input logic is_msg, input logic exp_ur);
    @(negedge mclk_i);
    txn_valid_i = 1'b1;
    txn_is_cfg_i = is_cfg;
    txn_is_slot_msg_i = is_msg;
    @(negedge mclk_i);
    txn_valid_i = 1'b0;
    `CHK(txn_done_o, 1'b1)
    `CHK(txn_ur_o, exp_ur)
  endtask : txn

  task automatic rd_class(input logic [1:0] cmd, input logic exp_pf);
    @(negedge mclk_i);
    rd_valid_i = 1'b1;
    rd_cmd_i = cmd;
    @(negedge mclk_i);
    rd_valid_i = 1'b0;
    `CHK(rd_done_o, 1'b1)
    `CHK(rd_prefetch_o, exp_pf)
  endtask : rd_class

  // Guards the whole run against a hang.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (3) @(negedge mclk_i);
    srst_i = 1'b0;
    chk_rd(8'hd4, 32'h0000025f);
    `CHK(min_power_mw_o, 18'h003b6)
    `CHK(limit_exceeded_o, 1'b0)
    cfg_access(1'b1, 8'hd4, 4'hf, 32'hffffffff);
    chk_rd(8'hd4, 32'h007fefff);
    `CHK({cap_fast_standby_latency_o, cap_deep_standby_latency_o}, 6'h3f)
    `CHK({stop_secondary_clocks_d3_o, beacon_wake_o}, 2'h3)
    `CHK(min_power_mw_o, 18'h000ff)
    cfg_access(1'b1, 8'hd8, 4'hf, 32'hffffffff);
    chk_rd(8'hd8, 32'h0);
    chk_rd(8'hd4, 32'h007fefff);
    pulse(pcie_fund_reset_i);
    chk_rd(8'hd4, 32'h00000e5f);
    pulse(global_reset_input_i);
    chk_rd(8'hd4, 32'h00000e5f);
    pulse(srst_i);
    chk_rd(8'hd4, 32'h0000025f);
    // Every scale code; the last one leaves a requirement of 95 mW.
    for (int s = 0; s < 4; s++) begin
      cfg_access(1'b1, 8'hd4, 4'h2, 32'(s) << 8);
      repeat (3) @(negedge mclk_i);
      `CHK(min_power_mw_o, exp_mw[s])
    end
    slot_msg(8'h5f, 2'h3);
    `CHK(limit_exceeded_o, 1'b0)
    slot_msg(8'h00, 2'h0);
    `CHK(limit_exceeded_o, 1'b1)
    // Every response code, reserved ones included, with the limit exceeded.
    for (int c = 0; c < 8; c++) begin
      cfg_access(1'b1, 8'hd4, 4'h4, 32'(c) << 20);
      repeat (2) @(negedge mclk_i);
      `CHK(power_exceeded_pin_o, (c == 1 || c == 3))
      `CHK(sec_clk_enable_o, (c == 2 || c == 3) ? ~clock_mask_i : {NCLK{1'b1}})
      txn(1'b0, 1'b0, (c == 4));
      txn(1'b1, 1'b0, 1'b0);
      txn(1'b0, 1'b1, 1'b0);
    end
    cfg_access(1'b1, 8'hd4, 4'h4, 32'h00300000);
    slot_msg(8'h5f, 2'h3);
    `CHK({limit_exceeded_o, power_exceeded_pin_o}, 2'h0)
    `CHK(sec_clk_enable_o, {NCLK{1'b1}})
    for (int r = 0; r < 4; r++) if (r != 2) rd_class(2'(r), 1'b1);
    cfg_access(1'b1, 8'hd4, 4'h4, 32'h00080000);
    for (int r = 0; r < 4; r++) if (r != 2) rd_class(2'(r), (r != 0));
    // Stop bit clear keeps clocks in D3; set stops them all.
    d3_state_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    `CHK(sec_clk_enable_o, {NCLK{1'b1}})
    cfg_access(1'b1, 8'hd4, 4'h2, 32'h00000b00);
    repeat (2) @(negedge mclk_i);
    `CHK(sec_clk_enable_o, {NCLK{1'b0}})
    d3_state_i = 1'b0;
    for (int l = 0; l < 8; l++) begin
      cfg_access(1'b1, 8'hd4, 4'h6, (32'(l) << 16) | (32'(l) << 13));
      @(negedge mclk_i);
      `CHK({cap_fast_standby_latency_o, cap_deep_standby_latency_o}, {2{l[2:0]}})
    end
    give_verdict();
  end
endmodule : bpgc_gen_ctrl_tb_top
